/* fspc_pkg.sv */
package fspc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX      = 8'h37;
  localparam logic [7:0] CTRL_BYTE_ADR = 8'hDC;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         BIT_STORE_EN  = 0;
  localparam int         BIT_PG_ERASE  = 1;
  localparam int         BIT_PG_WRITE  = 2;
  localparam int         BIT_RD_FUSE   = 3;
  localparam int         BIT_CLR_BUF   = 4;

  // ------------------------------------------------------------
  // legal command patterns in the low five bits
  // ------------------------------------------------------------
  localparam logic [4:0] CMD_CLR_BUF = 5'h11;
  localparam logic [4:0] CMD_RD_FUSE = 5'h09;
  localparam logic [4:0] CMD_WRITE   = 5'h05;
  localparam logic [4:0] CMD_ERASE   = 5'h03;
  localparam logic [4:0] CMD_LOAD    = 5'h01;

  // ------------------------------------------------------------
  // pointer layout and page geometry
  // ------------------------------------------------------------
  localparam int PAGE_WORDS = 32;
  localparam int WORD_W     = 5;
  localparam int WORD_LSB   = 1;
  localparam int PAGE_LSB   = WORD_LSB + WORD_W;
  localparam int PAGE_W     = 16 - PAGE_LSB;
  localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK      = 16'h0001;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [2:0] WIN_STORE    = 3'h4;
  localparam logic [2:0] WIN_LOAD     = 3'h3;
  localparam logic [2:0] LOAD_FLOOR   = WIN_STORE - WIN_LOAD;
  localparam longint     CLK_HZ       = 25000000;
  localparam longint     PROG_MIN_US  = 3700;
  localparam longint     PROG_MAX_US  = 4500;
  localparam longint     PROG_MIN_CYC = (PROG_MIN_US * CLK_HZ + 999999) / 1000000;
  localparam int         TMR_W        = 17;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] z;
    logic [15:0] data;
  } fspc_core_req_t;

  typedef struct packed {
    logic              erase;
    logic              prog;
    logic [PAGE_W-1:0] page;
    logic [WORD_W-1:0] word;
    logic [15:0]       data;
  } fspc_flash_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ERASE  = 4'h2,
    ST_STREAM = 4'h4,
    ST_WAIT   = 4'h8
  } fspc_state_t;

endpackage : fspc_pkg

/* fspc_top.sv */
`timescale 1ns/1ps
`default_nettype none

module fspc_top #(
  parameter int OP_CYCLES = int'(fspc_pkg::PROG_MIN_CYC)
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire fspc_pkg::fspc_core_req_t  core_req_i,
  output logic                           core_stall_o,
  output logic                           fuse_rd_valid_o,
  output logic      [7:0]                fuse_rd_data_o,
  input  wire logic                      eeprom_write_busy_flag_i,
  input  wire logic [7:0]                fuse_low_prog_i,
  input  wire logic [7:0]                fuse_high_prog_i,
  input  wire logic [1:0]                lock_prog_i,
  output fspc_pkg::fspc_flash_cmd_t      flash_cmd_o
);
  import fspc_pkg::*;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic cmd_legal(input logic [4:0] v);
    cmd_legal = (v == CMD_CLR_BUF) || (v == CMD_RD_FUSE) || (v == CMD_WRITE) ||
                (v == CMD_ERASE) || (v == CMD_LOAD);
  endfunction : cmd_legal

  function automatic logic [PAGE_W-1:0] page_of(input logic [15:0] z);
    page_of = z[15:PAGE_LSB];
  endfunction : page_of

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [4:0]        ctrl_r;
  logic [2:0]        win_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  fspc_state_t       state_r;
  logic [TMR_W-1:0]  tmr_r;
  logic [WORD_W-1:0] idx_r;
  logic              op_write_r;
  logic [PAGE_W-1:0] page_r;
  logic [15:0]       buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_vld_r;
  fspc_flash_cmd_t   flash_r;
  logic              fuse_vld_r;
  logic [7:0]        fuse_dat_r;

  logic              reg_hit;
  logic              reg_wr;
  logic              wr_ok;
  logic              op_busy;
  logic              op_done;
  logic              spm_take;
  logic              lpm_take;
  logic              start_erase;
  logic              start_write;
  logic              load_word;
  logic              clear_buf;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  always_comb begin
    if (wb_adr_i == CTRL_BYTE_ADR) begin
      reg_hit = 1'b1;
    end else begin
      reg_hit = 1'b0;
    end
  end

  // write takes effect on the edge where ack is high
  assign reg_wr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && reg_hit && wb_sel_i[0];
  assign wr_ok  = reg_wr && cmd_legal(wb_dat_i[4:0]) && !op_busy &&
                  !eeprom_write_busy_flag_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i && reg_hit) begin
      dat_r <= {27'h000_0000, ctrl_r};
    end else begin
      dat_r <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ------------------------------------------------------------
  // command arming and windows
  // ------------------------------------------------------------
  assign op_busy  = (state_r != ST_IDLE);
  assign op_done  = (state_r == ST_WAIT) && (tmr_r == '0);
  assign spm_take = core_req_i.store && ctrl_r[BIT_STORE_EN] && (win_r != 3'h0) &&
                    !op_busy && !eeprom_write_busy_flag_i;
  assign lpm_take = core_req_i.load && (ctrl_r == CMD_RD_FUSE) && (win_r > LOAD_FLOOR) &&
                    !eeprom_write_busy_flag_i;
  assign start_erase = spm_take && (ctrl_r == CMD_ERASE);
  assign start_write = spm_take && (ctrl_r == CMD_WRITE);
  assign load_word   = spm_take && (ctrl_r == CMD_LOAD);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET[4:0];
    end else if (wr_ok) begin
      ctrl_r <= wb_dat_i[4:0];
    end else if (op_done) begin
      ctrl_r <= 5'h00;
    end else if (op_busy || start_erase || start_write) begin
      ctrl_r <= ctrl_r;
    end else if (spm_take || lpm_take) begin
      ctrl_r <= 5'h00;
    end else if ((ctrl_r == CMD_RD_FUSE) && (win_r == LOAD_FLOOR + 3'h1)) begin
      ctrl_r <= 5'h00;
    end else if (win_r == 3'h1) begin
      ctrl_r <= 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_r <= 3'h0;
    end else if (wr_ok) begin
      win_r <= WIN_STORE;
    end else if (spm_take || lpm_take) begin
      win_r <= 3'h0;
    end else if (win_r != 3'h0) begin
      win_r <= win_r - 3'h1;
    end
  end

  // ------------------------------------------------------------
  // temporary page buffer
  // ------------------------------------------------------------
  assign clear_buf = (op_done && op_write_r) ||
                     (wr_ok && (wb_dat_i[4:0] == CMD_CLR_BUF)) ||
                     (eeprom_write_busy_flag_i && (buf_vld_r != '0));

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_buf) begin
      buf_vld_r <= '0;
    end else if (load_word) begin
      buf_vld_r[core_req_i.z[PAGE_LSB-1:WORD_LSB]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (load_word) begin
      buf_mem[core_req_i.z[PAGE_LSB-1:WORD_LSB]] <= core_req_i.data;
    end
  end

  // ------------------------------------------------------------
  // erase and write sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_IDLE;
      tmr_r      <= '0;
      idx_r      <= '0;
      op_write_r <= 1'b0;
      page_r     <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          idx_r <= '0;
          if (start_erase) begin
            state_r    <= ST_ERASE;
            op_write_r <= 1'b0;
            page_r     <= page_of(core_req_i.z);
          end else if (start_write) begin
            state_r    <= ST_STREAM;
            op_write_r <= 1'b1;
            page_r     <= page_of(core_req_i.z);
          end
        end
        ST_ERASE: begin
          state_r <= ST_WAIT;
          tmr_r   <= TMR_W'(OP_CYCLES - 1);
        end
        ST_STREAM: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == WORD_W'(PAGE_WORDS - 1)) begin
            state_r <= ST_WAIT;
            tmr_r   <= TMR_W'(OP_CYCLES - 1);
          end
        end
        ST_WAIT: begin
          if (tmr_r == '0) begin
            state_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // core halted from the accepted erase or write store until completion
  assign core_stall_o = op_busy || start_erase || start_write;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_r <= '0;
    end else begin
      flash_r.erase <= (state_r == ST_ERASE);
      flash_r.prog  <= (state_r == ST_STREAM);
      flash_r.page  <= page_r;
      flash_r.word  <= idx_r;
      flash_r.data  <= buf_vld_r[idx_r] ? buf_mem[idx_r] : ERASED_WORD;
    end
  end

  assign flash_cmd_o = flash_r;

  // ------------------------------------------------------------
  // fuse and lock read
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_vld_r <= 1'b0;
      fuse_dat_r <= 8'h00;
    end else begin
      fuse_vld_r <= lpm_take;
      if (lpm_take) begin
        if (core_req_i.z == Z_LOCK) begin
          fuse_dat_r <= {6'h3F, ~lock_prog_i};
        end else if (core_req_i.z == Z_FUSE_LOW) begin
          fuse_dat_r <= ~fuse_low_prog_i;
        end else if (core_req_i.z == Z_FUSE_HIGH) begin
          fuse_dat_r <= ~fuse_high_prog_i;
        end else begin
          fuse_dat_r <= 8'hFF;
        end
      end
    end
  end

  assign fuse_rd_valid_o = fuse_vld_r;
  assign fuse_rd_data_o  = fuse_dat_r;

endmodule : fspc_top

`default_nettype wire

/* fspc_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fspc_asserts (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [31:0]              wb_dat_o,
  input  wire logic                     wb_ack_o,
  input  wire fspc_pkg::fspc_core_req_t core_req_i,
  input  wire logic                     core_stall_o,
  input  wire logic                     fuse_rd_valid_o,
  input  wire logic                     eeprom_write_busy_flag_i,
  input  wire fspc_pkg::fspc_flash_cmd_t flash_cmd_o
);
  import fspc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence prog_start;
    $rose(flash_cmd_o.prog);
  endsequence
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  a_resv_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CTRL_BYTE_ADR |-> wb_dat_o[31:5] == '0)
    else $error("reserved bits set");
  a_erase_pulse: assert property (flash_cmd_o.erase |-> core_stall_o ##1 !flash_cmd_o.erase)
    else $error("erase pulse wrong");
  a_prog_begin: assert property (prog_start |-> flash_cmd_o.word == 5'h00 ##1 flash_cmd_o.prog [*7])
    else $error("page stream start wrong");
  a_word_step: assert property (flash_cmd_o.prog && $past(flash_cmd_o.prog) |-> flash_cmd_o.word == $past(flash_cmd_o.word) + 5'h01)
    else $error("word order wrong");
  a_prog_end: assert property ($fell(flash_cmd_o.prog) |-> $past(flash_cmd_o.word) == 5'h1F && core_stall_o)
    else $error("page stream end wrong");
  a_fuse_load: assert property (fuse_rd_valid_o |-> $past(core_req_i.load) && !$past(eeprom_write_busy_flag_i))
    else $error("fuse answer without load");
  a_stall_cause: assert property (core_stall_o && !$past(core_stall_o) |-> core_req_i.store && !eeprom_write_busy_flag_i)
    else $error("stall without store");
endmodule : fspc_asserts
bind fspc_top fspc_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_req_i(core_req_i),
  .core_stall_o(core_stall_o), .fuse_rd_valid_o(fuse_rd_valid_o),
  .eeprom_write_busy_flag_i(eeprom_write_busy_flag_i), .flash_cmd_o(flash_cmd_o));
`default_nettype wire

/* fspc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fspc_core_model (
  input  wire logic                    clk_i,
  output var fspc_pkg::fspc_core_req_t req_o
);
  import fspc_pkg::*;
  initial req_o = '0;
  // one store or load pulse, pointer and data released to inverse after
  task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] d);
    req_o <= '{store: st, load: !st, z: z, data: d};
    @(posedge clk_i);
    req_o <= '{store: 1'b0, load: 1'b0, z: ~z, data: ~d};
  endtask : issue
endmodule : fspc_core_model
`default_nettype wire

/* test_flash_self_program_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_control;
  import fspc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0;
  logic [7:0] adr = 8'h00, fl = 8'h00, fh = 8'h00;
  logic [31:0] dat = 32'h0, rdat;
  logic [3:0] sel = 4'hF;
  logic [1:0] lk = 2'h0;
  logic ack, stall, fvalid;
  logic [7:0] fdata;
  fspc_core_req_t core_req;
  fspc_flash_cmd_t fc;
  logic [15:0] exp_buf [32];
  logic [15:0] got [32];
  logic [9:0] er_pg, wr_pg;
  int num_errors = 0, n_compared = 0;
  always #20 clk_i = ~clk_i;
  fspc_top #(.OP_CYCLES(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .core_req_i(core_req),
    .core_stall_o(stall), .fuse_rd_valid_o(fvalid), .fuse_rd_data_o(fdata), .eeprom_write_busy_flag_i(busy),
    .fuse_low_prog_i(fl), .fuse_high_prog_i(fh), .lock_prog_i(lk), .flash_cmd_o(fc));
  fspc_core_model u_core (.clk_i(clk_i), .req_o(core_req));
  always @(posedge clk_i) begin
    if (fc.prog) got[fc.word] <= fc.data;
    if (fc.prog) wr_pg <= fc.page;
    if (fc.erase) er_pg <= fc.page;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(negedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = rdat;
    @(posedge clk_i);
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic ctrl_is(input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, CTRL_BYTE_ADR, 32'h0, q);
    check(q, e);
  endtask : ctrl_is
  task automatic load_word(input logic [4:0] s, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, CTRL_BYTE_ADR, 32'h01, q);
    u_core.issue(1'b1, {10'($urandom), s, 1'($urandom)}, d);
    exp_buf[s] = d;
  endtask : load_word
  task automatic page_write(input logic [9:0] pg);
    logic [31:0] q;
    int n;
    wb(1'b1, CTRL_BYTE_ADR, 32'h05, q);
    u_core.issue(1'b1, {pg, 6'h00}, 16'h1234);
    @(negedge clk_i);
    check(stall, 1'b1);
    n = 0;
    while (stall !== 1'b0 && n < 300) begin @(negedge clk_i); n++; end
    check(32'(n < 300), 32'h1);
    for (int i = 0; i < 32; i++) check(got[i], exp_buf[i]);
    check(wr_pg, pg);
    ctrl_is(32'h0);
    exp_buf = '{default: 16'hFFFF};
  endtask : page_write
  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    #(40 * 6000);
    num_errors++;
    print_verdict();
  end
  initial begin
    logic [31:0] q;
    logic [15:0] z;
    logic [7:0] e;
    logic [4:0] cmds [6];
    exp_buf = '{default: 16'hFFFF};
    void'($urandom(68));
    {fl, fh, lk} = 18'($urandom);
    cmds = '{5'h05, 5'h03, 5'h09, 5'h11, 5'h07, 5'($urandom) | 5'h12};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ctrl_is(32'(CTRL_RESET));
    wb(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, CTRL_BYTE_ADR, 32'hE1, q);
    ctrl_is(32'h01);
    foreach (cmds[i]) begin
      wb(1'b1, CTRL_BYTE_ADR, {27'h0, cmds[i]}, q);
      repeat (6) @(posedge clk_i);
      ctrl_is(32'h0);
    end
    for (int i = 0; i < 10; i++) load_word(5'(i * 3), 16'($urandom));
    wb(1'b1, CTRL_BYTE_ADR, 32'h01, q);
    repeat (6) @(posedge clk_i);
    u_core.issue(1'b1, 16'h003F, 16'h5A5A);
    page_write(10'($urandom));
    page_write(10'h3FF);
    load_word(5'h02, 16'hBEEF);
    wb(1'b1, CTRL_BYTE_ADR, 32'h11, q);
    exp_buf = '{default: 16'hFFFF};
    page_write(10'h001);
    load_word(5'h04, 16'hCAFE);
    busy <= 1'b1;
    wb(1'b1, CTRL_BYTE_ADR, 32'h09, q);
    ctrl_is(32'h0);
    busy <= 1'b0;
    exp_buf = '{default: 16'hFFFF};
    page_write(10'h2AA);
    z = 16'($urandom);
    wb(1'b1, CTRL_BYTE_ADR, 32'h03, q);
    u_core.issue(1'b1, z, 16'h0);
    repeat (30) @(posedge clk_i);
    check(er_pg, z[15:6]);
    ctrl_is(32'h0);
    foreach (cmds[i]) if (i < 3) begin
      z = (i == 0) ? Z_FUSE_LOW : (i == 1) ? Z_LOCK : Z_FUSE_HIGH;
      e = (i == 0) ? ~fl : (i == 1) ? {6'h0, ~lk} : ~fh;
      wb(1'b1, CTRL_BYTE_ADR, 32'h09, q);
      u_core.issue(1'b0, z, 16'h0);
      @(negedge clk_i);
      check(fvalid, 1'b1);
      check(fdata & ((i == 1) ? 8'h03 : 8'hFF), e);
      ctrl_is(32'h0);
    end
    print_verdict();
  end
endmodule : test_flash_self_program_control
`default_nettype wire
